// >>> rtl/fan_lut_step2_defines.svh
// Register offsets, field positions, reset values for the lookup-table step
`ifndef FAN_LUT_STEP2_DEFINES_SVH
`define FAN_LUT_STEP2_DEFINES_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define IDX_LUT_CTRL        10'h04A
`define IDX_LUT_TEMP_OFFSET 10'h04E
`define IDX_STEP2_LIMIT     10'h052
`define IDX_STEP2_DUTY      10'h053
`define IDX_STEP2_STATUS    10'h060

// ============================================================
// Control register fields
`define CTRL_TEMP_HIRES_BIT 0
`define CTRL_DUTY_HIRES_BIT 1
`define CTRL_PWM_22K_BIT    2
`define CTRL_WRITE_EN_BIT   5

// ============================================================
// Field positions inside the step registers
`define LIMIT_TOP_BIT       7
`define DUTY_EXT_MSB        7
`define DUTY_EXT_LSB        6
`define DUTY_BASE_MSB       5

// ============================================================
// Reset values
`define RST_STEP2_LIMIT     8'h7F
`define RST_STEP2_DUTY      8'h3F
`define RST_LUT_CTRL        8'h00
`define RST_LUT_TEMP_OFFSET 8'h00

`endif

// >>> rtl/fan_lut_step2_pkg.sv
// Types shared by the lookup-table step design files
package fan_lut_step2_pkg;

    // Bus answer sequencer
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_type;

    // Register byte value
    typedef logic [7:0] reg_byte_type;

endpackage

// >>> rtl/step_eval_if.sv
// Bundle between the register bank and the threshold evaluator
`timescale 1ns/1ns
interface step_eval_if;
    logic [8:0] temp;      // Remote temperature, LSB 0.5 degree
    logic [7:0] limit;     // Stored limit byte
    logic [7:0] duty;      // Stored duty byte
    logic [7:0] offset;    // Table offset, whole degrees
    logic       temp_hires; // High-resolution temperature mode
    logic       duty_hires; // High-resolution duty mode, gated by PWM rate
    logic       exceeds;   // Temperature above effective threshold
    logic [7:0] duty_sel;  // Duty value offered by this step

    modport bank (output temp, limit, duty, offset, temp_hires, duty_hires,
                  input exceeds, duty_sel);
    modport evaluator (input temp, limit, duty, offset, temp_hires, duty_hires,
                       output exceeds, duty_sel);
endinterface // step_eval_if

// >>> rtl/fan_step_eval.sv
// Threshold comparison and duty selection for one table step
`timescale 1ns/1ns
`include "fan_lut_step2_defines.svh"
module fan_step_eval (
    step_eval_if.evaluator ev
);

    // ============================================================
    // Threshold and comparison
    logic [9:0] thr_hi;    // High-res threshold, half-degree units
    logic [8:0] thr_lo;    // Low-res threshold, whole degrees
    logic [6:0] step2_limit_low_bits;
    logic       step2_limit_top_bit;

    // Sign bit is never stored, so every threshold is positive
    always_comb begin
        step2_limit_low_bits = ev.limit[6:0];
        step2_limit_top_bit  = ev.limit[`LIMIT_TOP_BIT] & ev.temp_hires;
        // Top bit joins the low bits in high resolution
        thr_hi = {2'b00, step2_limit_top_bit, step2_limit_low_bits}
               + {1'b0, ev.offset, 1'b0};
        thr_lo = {2'b00, step2_limit_low_bits} + {1'b0, ev.offset};
        // Nine reading bits in high resolution, eight in low
        if (ev.temp_hires) begin
            ev.exceeds = {1'b0, ev.temp} > thr_hi;
        end else begin
            ev.exceeds = {1'b0, ev.temp[8:1]} > thr_lo;
        end
    end

    // ============================================================
    // Duty selection
    logic [1:0] step2_duty_extended_bits;
    logic [5:0] step2_duty_base_bits;

    // Extended bits count only when the bank allows them
    always_comb begin
        step2_duty_base_bits     = ev.duty[`DUTY_BASE_MSB:0];
        step2_duty_extended_bits = ev.duty_hires
                                 ? ev.duty[`DUTY_EXT_MSB:`DUTY_EXT_LSB] : 2'b00;
        ev.duty_sel = {step2_duty_extended_bits, step2_duty_base_bits};
    end

endmodule // fan_step_eval

// >>> rtl/fan_lut_entry_two.sv
// Lookup-table step two: registers, Wishbone slave and fan duty output
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`include "fan_lut_step2_defines.svh"
module fan_lut_entry_two #(
    parameter int ADDR_W = 12   // Byte address width on the bus
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Temperature from the conversion logic
    input  wire logic [8:0]        remote_temp_i,
    // To the PWM generator
    output logic                   step_active_o,
    output logic      [7:0]        pwm_duty_o
);

    // ============================================================
    // Address decode and register view helpers

    // Word index of a byte address; misaligned maps to nothing
    function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] sh;
        sh = a >> 2;
        word_index = (a[1:0] == 2'b00) ? sh[9:0] : 10'h3FF;
    endfunction

    // Limit byte as seen by software and comparator
    function automatic logic [7:0] limit_view(input logic [7:0] raw, input logic hires);
        limit_view = hires ? raw : {1'b0, raw[6:0]};
    endfunction

    // Duty byte as seen by software
    function automatic logic [7:0] duty_view(input logic [7:0] raw, input logic hires);
        duty_view = hires ? raw : {2'b00, raw[5:0]};
    endfunction

    // ============================================================
    // Register state
    fan_lut_step2_pkg::reg_byte_type  lut_step2_temp_limit_q, lut_step2_temp_limit_d;
    fan_lut_step2_pkg::reg_byte_type  lut_step2_duty_q, lut_step2_duty_d;
    fan_lut_step2_pkg::reg_byte_type  ctrl_q, ctrl_d;     // Table control
    fan_lut_step2_pkg::reg_byte_type  offset_q, offset_d; // Table offset
    fan_lut_step2_pkg::bus_state_type bus_q, bus_d;       // Answer sequencer
    logic [31:0]                      rdata_q, rdata_d;   // Read data flop

    // Output flops
    logic       active_q, active_d;
    logic [7:0] duty_out_q, duty_out_d;

    // Decoded request
    logic [9:0] idx;         // Word index of the request
    logic       req;         // Request present
    logic       commit;      // Edge where the master samples ack
    logic       wr_lane0;    // Write that touches byte lane 0
    logic       table_wen;   // Table unlocked for writes
    logic       temp_hires;  // Temperature resolution mode
    logic       duty_hires;  // Duty resolution mode, effective

    always_comb begin
        idx        = word_index(adr_i);
        req        = cyc_i & stb_i;
        commit     = req & (bus_q == fan_lut_step2_pkg::BUS_ACK);
        wr_lane0   = commit & we_i & sel_i[0];
        table_wen  = ctrl_q[`CTRL_WRITE_EN_BIT];
        temp_hires = ctrl_q[`CTRL_TEMP_HIRES_BIT];
        // Extended duty bits are dead at slow PWM rates
        duty_hires = ctrl_q[`CTRL_DUTY_HIRES_BIT] & ctrl_q[`CTRL_PWM_22K_BIT];
    end

    // ============================================================
    // Evaluator
    step_eval_if ev_if ();

    always_comb begin
        ev_if.temp       = remote_temp_i;
        ev_if.limit      = lut_step2_temp_limit_q;
        ev_if.duty       = lut_step2_duty_q;
        ev_if.offset     = offset_q;
        ev_if.temp_hires = temp_hires;
        ev_if.duty_hires = duty_hires;
    end

    fan_step_eval i_fan_step_eval (
        .ev (ev_if.evaluator)
    );

    // ============================================================
    // Bus sequencer: ack one cycle after the request appears
    always_comb begin
        case (bus_q)
            fan_lut_step2_pkg::BUS_IDLE: begin
                // New request gets an answer next cycle
                bus_d = req ? fan_lut_step2_pkg::BUS_ACK : fan_lut_step2_pkg::BUS_IDLE;
            end
            fan_lut_step2_pkg::BUS_ACK: begin
                // Ack lasts one cycle, master must release
                bus_d = fan_lut_step2_pkg::BUS_IDLE;
            end
            default: begin
                bus_d = fan_lut_step2_pkg::BUS_IDLE;
            end
        endcase
    end

    // ============================================================
    // Read data, captured when the answer is issued
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (req && (bus_q == fan_lut_step2_pkg::BUS_IDLE) && !we_i) begin
            case (idx)
                `IDX_STEP2_LIMIT: begin
                    // Always readable; top bit masked in low mode
                    rdata_d[7:0] = limit_view(lut_step2_temp_limit_q, temp_hires);
                end
                `IDX_STEP2_DUTY: begin
                    // Upper bits masked in low duty mode
                    rdata_d[7:0] = duty_view(lut_step2_duty_q, duty_hires);
                end
                `IDX_LUT_CTRL: begin
                    rdata_d[7:0] = ctrl_q;
                end
                `IDX_LUT_TEMP_OFFSET: begin
                    rdata_d[7:0] = offset_q;
                end
                `IDX_STEP2_STATUS: begin
                    // Live view of the step's decision
                    rdata_d[0]    = active_q;
                    rdata_d[15:8] = duty_out_q;
                end
                default: begin
                    // Unmapped reads return zero
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // ============================================================
    // Register writes, taken at the ack edge only
    always_comb begin
        lut_step2_temp_limit_d = lut_step2_temp_limit_q;
        lut_step2_duty_d       = lut_step2_duty_q;
        ctrl_d                 = ctrl_q;
        offset_d               = offset_q;
        if (wr_lane0) begin
            case (idx)
                `IDX_STEP2_LIMIT: begin
                    // Locked table silently drops the write
                    if (table_wen) begin
                        lut_step2_temp_limit_d = limit_view(dat_i[7:0], temp_hires);
                    end
                end
                `IDX_STEP2_DUTY: begin
                    if (table_wen) begin
                        lut_step2_duty_d = duty_view(dat_i[7:0], duty_hires);
                    end
                end
                `IDX_LUT_CTRL: begin
                    ctrl_d = dat_i[7:0];
                end
                `IDX_LUT_TEMP_OFFSET: begin
                    offset_d = dat_i[7:0];
                end
                default: begin
                    // Unmapped or read-only: ignored
                    ctrl_d = ctrl_q;
                end
            endcase
        end
    end

    // ============================================================
    // Fan output: step duty while above threshold, else zero
    always_comb begin
        active_d   = ev_if.exceeds;
        duty_out_d = ev_if.exceeds ? ev_if.duty_sel : 8'h00;
    end

    // ============================================================
    // All flops, synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lut_step2_temp_limit_q <= `RST_STEP2_LIMIT;
            lut_step2_duty_q       <= `RST_STEP2_DUTY;
            ctrl_q                 <= `RST_LUT_CTRL;
            offset_q               <= `RST_LUT_TEMP_OFFSET;
            bus_q                  <= fan_lut_step2_pkg::BUS_IDLE;
            rdata_q                <= 32'h0000_0000;
            active_q               <= 1'b0;
            duty_out_q             <= 8'h00;
        end else begin
            lut_step2_temp_limit_q <= lut_step2_temp_limit_d;
            lut_step2_duty_q       <= lut_step2_duty_d;
            ctrl_q                 <= ctrl_d;
            offset_q               <= offset_d;
            bus_q                  <= bus_d;
            rdata_q                <= rdata_d;
            active_q               <= active_d;
            duty_out_q             <= duty_out_d;
        end
    end

    // Outputs straight from flops
    assign ack_o         = (bus_q == fan_lut_step2_pkg::BUS_ACK);
    assign dat_o         = rdata_q;
    assign step_active_o = active_q;
    assign pwm_duty_o    = duty_out_q;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Reset leaves documented table values; must not be masked by the reset it checks
    property p_reset_values;
        disable iff (1'b0)
        rst_i |=> (lut_step2_temp_limit_q == 8'h7F) && (lut_step2_duty_q == 8'h3F);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    // Low temperature mode reads bit 7 as zero
    property p_limit_top_low;
        (req && !we_i && bus_q == fan_lut_step2_pkg::BUS_IDLE && idx == `IDX_STEP2_LIMIT && !temp_hires)
            |=> ack_o && !dat_o[7];
    endproperty
    a_limit_top_low: assert property (p_limit_top_low) else $error("limit top bit not zero");

    // High mode, no offset: reading above the full 8-bit limit activates step
    property p_hires_cmp;
        (temp_hires && offset_q == 8'h00 && remote_temp_i > {1'b0, lut_step2_temp_limit_q})
            |=> step_active_o;
    endproperty
    a_hires_cmp: assert property (p_hires_cmp) else $error("high-res compare missed");

    // Low mode with no offset: 128 degrees or more always exceeds
    property p_lowres_range;
        (!temp_hires && offset_q == 8'h00 && remote_temp_i[8]) |=> step_active_o;
    endproperty
    a_lowres_range: assert property (p_lowres_range) else $error("low-res range exceeded");

    // Low mode ignores the half-degree reading bit
    property p_lowres_half_bit;
        (!temp_hires && remote_temp_i[8:1] == {1'b0, lut_step2_temp_limit_q[6:0]})
            |=> !step_active_o;
    endproperty
    a_lowres_half_bit: assert property (p_lowres_half_bit) else $error("half bit used");

    // Offset raises the threshold
    property p_offset_raises;
        (!temp_hires && remote_temp_i[8:1] <= offset_q) |=> !step_active_o;
    endproperty
    a_offset_raises: assert property (p_offset_raises) else $error("offset not applied");

    // Active step drives the stored duty
    property p_duty_drive;
        step_active_o |-> pwm_duty_o == duty_view($past(lut_step2_duty_q), $past(duty_hires));
    endproperty
    a_duty_drive: assert property (p_duty_drive) else $error("wrong duty driven");

    // Low duty mode reads upper bits as zero
    property p_duty_ext_read;
        (req && !we_i && bus_q == fan_lut_step2_pkg::BUS_IDLE && idx == `IDX_STEP2_DUTY && !duty_hires)
            |=> ack_o && dat_o[7:6] == 2'b00;
    endproperty
    a_duty_ext_read: assert property (p_duty_ext_read) else $error("duty upper bits not zero");

    // Slow PWM rate never shows extended bits
    property p_slow_pwm;
        !$past(ctrl_q[`CTRL_PWM_22K_BIT]) |-> pwm_duty_o[7:6] == 2'b00;
    endproperty
    a_slow_pwm: assert property (p_slow_pwm) else $error("extended bits at slow rate");

    // Locked table keeps limit and duty across any write
    property p_locked_write;
        (commit && we_i && !table_wen) |=> $stable(lut_step2_temp_limit_q) && $stable(lut_step2_duty_q);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("write while locked");

    // Ack is exactly one cycle wide
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

    c_unlocked_write: cover property (commit && we_i && table_wen && idx == `IDX_STEP2_LIMIT);
    c_step_active:    cover property (!step_active_o ##1 step_active_o);
    c_hires_duty:     cover property (step_active_o && pwm_duty_o[7:6] != 2'b00);

endmodule // fan_lut_entry_two

// >>> test/fan_lut_entry_two_test.sv
// Self-checking bench for the lookup-table step two register block
`timescale 1ns/1ns
`include "fan_lut_step2_defines.svh"
module fan_lut_entry_two_test;
    // ============================================================
    // Byte addresses of the registers (index shifted by two)
    localparam logic [11:0] A_CTRL   = {`IDX_LUT_CTRL, 2'b00};
    localparam logic [11:0] A_OFFSET = {`IDX_LUT_TEMP_OFFSET, 2'b00};
    localparam logic [11:0] A_LIMIT  = {`IDX_STEP2_LIMIT, 2'b00};
    localparam logic [11:0] A_DUTY   = {`IDX_STEP2_DUTY, 2'b00};
    localparam logic [11:0] A_STATUS = {`IDX_STEP2_STATUS, 2'b00};

    // ============================================================
    // Design stimulus and observation
    logic        clk_i         = 1'b0;  // 125 MHz clock
    logic        rst_i         = 1'b1;  // Held high from time zero
    logic        cyc_i         = 1'b0;  // Bus cycle
    logic        stb_i         = 1'b0;  // Bus strobe
    logic        we_i          = 1'b0;  // Write select
    logic [11:0] adr_i         = 12'h000; // Byte address
    logic [3:0]  sel_i         = 4'h0;  // Byte lanes
    logic [31:0] dat_i         = 32'h0000_0000; // Write data
    logic [31:0] dat_o;                 // Read data
    logic        ack_o;                 // Bus answer
    logic [8:0]  remote_temp_i = 9'h000; // Half-degree temperature
    logic        step_active_o;         // Step above threshold
    logic [7:0]  pwm_duty_o;            // Offered duty
    int          mismatches    = 0;     // Failed comparisons
    int          tests_run     = 0;     // All comparisons

    fan_lut_entry_two #(.ADDR_W(12)) i_fan_lut_entry_two (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .remote_temp_i(remote_temp_i), .step_active_o(step_active_o), .pwm_duty_o(pwm_duty_o)
    );

    // ============================================================
    // Clock generator, half period 4 ns
    always #4 clk_i = ~clk_i;

    // ============================================================
    // Shared helpers
    // Compare seen against expected, four-state exact
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb_cycle(input logic [11:0] a, input logic w, input logic [7:0] d,
                            input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        // Data is taken at the ack edge only, then the request drops
        r = dat_o;
        check({31'h0, ack_o}, 32'h0000_0001);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    // Full-lane write
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb_cycle(a, 1'b1, d, 4'hF, r);
    endtask

    // Read and compare the whole word, upper bits included
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb_cycle(a, 1'b0, 8'h00, 4'hF, r);
        check(r, exp);
    endtask

    // Apply a temperature; outputs follow one edge later
    task automatic temp_chk(input logic [8:0] t, input logic act, input logic [7:0] duty);
        @(posedge clk_i);
        remote_temp_i <= t;
        repeat (2) @(posedge clk_i);
        check({31'h0, step_active_o}, {31'h0, act});
        check({24'h0, pwm_duty_o}, {24'h0, duty});
    endtask

    // Verdict; reached from the main sequence or the watchdog
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ============================================================
    // Watchdog, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        wrap_up();
    end

    // ============================================================
    // Main sequence
    initial begin
        logic [31:0] junk;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Power-on state, table locked
        rd_chk(A_LIMIT, 32'h0000_007F);
        rd_chk(A_DUTY, 32'h0000_003F);
        wr(A_LIMIT, 8'h10);
        rd_chk(A_LIMIT, 32'h0000_007F);
        wr(A_DUTY, 8'h01);
        rd_chk(A_DUTY, 32'h0000_003F);
        // Unlock, low resolution for both fields
        wr(A_CTRL, 8'h20);
        wr(A_LIMIT, 8'hC5);
        rd_chk(A_LIMIT, 32'h0000_0045);
        wr(A_DUTY, 8'hFF);
        rd_chk(A_DUTY, 32'h0000_003F);
        wb_cycle(A_LIMIT, 1'b1, 8'h33, 4'hE, junk);
        rd_chk(A_LIMIT, 32'h0000_0045);
        // Low mode: half-degree bit ignored, 69 degrees limit
        temp_chk(9'h08B, 1'b0, 8'h00);
        temp_chk(9'h08C, 1'b1, 8'h3F);
        rd_chk(A_STATUS, 32'h0000_3F01);
        // Offset of one degree raises the threshold to 70
        wr(A_OFFSET, 8'h01);
        temp_chk(9'h08C, 1'b0, 8'h00);
        temp_chk(9'h08E, 1'b1, 8'h3F);
        wr(A_OFFSET, 8'h00);
        // High resolution temperature: top bit joins the low bits
        wr(A_CTRL, 8'h21);
        wr(A_LIMIT, 8'h90);
        rd_chk(A_LIMIT, 32'h0000_0090);
        temp_chk(9'h090, 1'b0, 8'h00);
        temp_chk(9'h091, 1'b1, 8'h3F);
        // Full-scale limit is 127.5 degrees, never a negative value
        wr(A_LIMIT, 8'hFF);
        temp_chk(9'h0FF, 1'b0, 8'h00);
        temp_chk(9'h100, 1'b1, 8'h3F);
        // Offset of two degrees reaches beyond 127.5
        wr(A_OFFSET, 8'h02);
        temp_chk(9'h103, 1'b0, 8'h00);
        temp_chk(9'h104, 1'b1, 8'h3F);
        wr(A_OFFSET, 8'h00);
        // Back to low mode: stored top bit hidden
        wr(A_CTRL, 8'h20);
        rd_chk(A_LIMIT, 32'h0000_007F);
        temp_chk(9'h0FF, 1'b0, 8'h00);
        // Extended duty with the fast PWM rate selected
        wr(A_CTRL, 8'h27);
        wr(A_DUTY, 8'hC5);
        rd_chk(A_DUTY, 32'h0000_00C5);
        temp_chk(9'h100, 1'b1, 8'hC5);
        // Without the fast rate the extended bits do nothing
        wr(A_CTRL, 8'h23);
        temp_chk(9'h100, 1'b1, 8'h05);
        wr(A_CTRL, 8'h20);
        rd_chk(A_DUTY, 32'h0000_0005);
        temp_chk(9'h100, 1'b1, 8'h05);
        // Unmapped places read zero; status ignores writes
        rd_chk(12'h149, 32'h0000_0000);
        rd_chk(12'hFFC, 32'h0000_0000);
        wr(A_STATUS, 8'h00);
        rd_chk(A_STATUS, 32'h0000_0501);
        // Reset in mid-run restores the power-on values
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(A_LIMIT, 32'h0000_007F);
        rd_chk(A_DUTY, 32'h0000_003F);
        wrap_up();
    end
endmodule // fan_lut_entry_two_test
